// ==== core/branch_condition_evaluator.sv ====
// Branch condition evaluator with flag register and AHB-Lite register slave.
//
// What this block does
// - Field 1000 always taken, 0000 never.
// - 0111 taken on carry, 1111 without.
// - 0011 taken on carry or zero.
// - 1011 taken when carry, zero clear.
// - 1010 taken: zero clear, sign equals wrap.
// - 0010 taken: zero set or sign differs.
// - 1001 sign equals wrap; 0001 differs.
// - Six flags held at register 252.
// - Flags cleared, set, updated, kept, undefined.
`timescale 1ns/1ps
module branch_condition_evaluator
   import cond_eval_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         reset,
   // AHB-Lite slave.
   input  wire logic         hsel,
   input  wire logic [7:0]   haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic [31:0]  hwdata,
   input  wire logic         hready,
   output logic [31:0]       hrdata,
   output logic              hreadyout,
   output logic              hresp,
   // Core side.
   input  wire logic [3:0]   cond_field,
   input  wire flag_update_t flag_update,
   output logic [7:0]        flags_out,
   output logic              branch_taken
);

   // Address decode shared by the write and read paths.
   function automatic logic [1:0] decode(input logic [7:0] a);
      unique case (a)
         ADDR_CONDITION_FLAGS: decode = 2'h1;
         ADDR_CORE_CONTROL:    decode = 2'h2;
         ADDR_BRANCH_STATUS:   decode = 2'h3;
         default:              decode = 2'h0;
      endcase
   endfunction

   // Address phase captured for the data phase.
   logic        wr_pend;
   logic        rd_pend;
   logic [7:0]  addr_q;
   logic        next_wr_pend;
   logic        next_rd_pend;
   logic [7:0]  next_addr_q;
   logic        accept;

   // Register state. condition_flags holds carry, zero, sign, wrap, decimal-adjust
   // and half-carry from bit 7 down to bit 2; bits 1:0 are not stored and read as 0.
   // core_control keeps a condition code for the status word, an apply strobe and an
   // action code; every other bit is plain storage that software reads back.
   logic [7:0]  condition_flags;
   logic [31:0] core_control;
   logic [7:0]  next_flags;
   logic [31:0] next_control;
   logic [31:0] next_hrdata;
   logic        next_taken;
   logic        sw_taken;
   logic        core_taken;
   cond_flags_t live_flags;
   logic [31:0] status_word;

   // Accept only word-sized NONSEQ or SEQ transfers; others are ignored but still answered OKAY.
   // The slave never stalls, so an accepted address phase always has its data phase in
   // the very next cycle and one capture register per request kind is enough.
   assign accept = hsel & hready
                 & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ)
                 & (hsize == HSIZE_WORD);

   // Next values of the captured address phase.
   always_comb begin
      next_wr_pend = accept & hwrite;
      next_rd_pend = accept & ~hwrite;
      next_addr_q  = accept ? haddr : addr_q;
   end

   // The address phase is kept for the data phase, which is when hwdata arrives.
   // addr_q keeps its last value between transfers; only the pend bits qualify it.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         addr_q  <= 8'h00;
      end else begin
         wr_pend <= next_wr_pend;
         rd_pend <= next_rd_pend;
         addr_q  <= next_addr_q;
      end
   end

   // The four flags the decision reads, gathered in the evaluator's order.
   assign live_flags = cond_flags_t'({condition_flags[FLAG_C], condition_flags[FLAG_Z],
                                      condition_flags[FLAG_S], condition_flags[FLAG_V]});

   // Core evaluation on the live flags; only the core's cond_field is evaluated here.
   cond_decide u_core_decide (
      .flags (live_flags),
      .cond  (cond_field),
      .taken (core_taken)
   );

   // The status register shows the decision for the code software placed in control.
   // Only one decision unit exists, so a stored code other than always or never is
   // reported only while the core presents that same code; otherwise the bit reads 0.
   always_comb begin
      sw_taken = 1'b0;
      unique case (cond_code_t'(core_control[CTRL_COND_LSB +: 4]))
         COND_ALWAYS: sw_taken = 1'b1;
         COND_NEVER:  sw_taken = 1'b0;
         default:     sw_taken = core_taken & (cond_field == core_control[CTRL_COND_LSB +: 4]);
      endcase
   end

   // Flag register: bus write wins over a core update in the same cycle, since
   // software restoring flags must not be overwritten by a stale instruction.
   always_comb begin
      next_flags   = condition_flags;
      next_control = core_control;
      if (flag_update.valid) begin
         for (int i = 0; i < FLAG_COUNT; i++) begin
            unique case (flag_update.act[i])
               ACT_CLEAR:  next_flags[FLAG_H + i] = 1'b0;
               ACT_SET:    next_flags[FLAG_H + i] = 1'b1;
               ACT_RESULT: next_flags[FLAG_H + i] = flag_update.result[i];
               ACT_UNDEF:  next_flags[FLAG_H + i] = flag_update.result[i];
               default:    next_flags[FLAG_H + i] = condition_flags[FLAG_H + i];
            endcase
         end
      end

      // A bus write of a whole register replaces what the core update produced.
      if (wr_pend) begin
         unique case (decode(addr_q))
            2'h1:    next_flags = hwdata[7:0] & FLAGS_MASK;
            2'h2:    next_control = hwdata;
            default: next_control = core_control;
         endcase
      end

      // Software can also apply a stored action set to every flag at once.
      // Only clear and set act here: a bus write carries no operation result.
      if (wr_pend && decode(addr_q) == 2'h2 && hwdata[CTRL_APPLY]) begin
         for (int i = 0; i < FLAG_COUNT; i++) begin
            unique case (flag_act_t'(hwdata[CTRL_ACT_LSB +: ACT_WIDTH]))
               ACT_CLEAR: next_flags[FLAG_H + i] = 1'b0;
               ACT_SET:   next_flags[FLAG_H + i] = 1'b1;
               default:   next_flags[FLAG_H + i] = next_flags[FLAG_H + i];
            endcase
         end
         next_control[CTRL_APPLY] = 1'b0;
      end
   end

   // Register state, cleared by reset. Flags and control change only at clock edges,
   // so the decision path never sees a half-written register.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         condition_flags <= RESET_FLAGS[7:0];
         core_control    <= RESET_CONTROL;
      end else begin
         condition_flags <= next_flags;
         core_control    <= next_control;
      end
   end

   // Branch status word: bit 0 is the core's decision, bit 1 the stored code's.
   assign status_word = {30'h0, sw_taken, core_taken};

   // Read data is registered in the address phase so it stands in the data phase.
   // The flag and control values are the ones the edge ending the address phase
   // stores, so a read issued right behind a write already sees the new value.
   always_comb begin
      next_hrdata = 32'h0000_0000;
      if (accept && !hwrite) begin
         unique case (decode(haddr))
            2'h1:    next_hrdata = {24'h00_0000, next_flags};
            2'h2:    next_hrdata = next_control;
            2'h3:    next_hrdata = status_word;
            default: next_hrdata = 32'h0000_0000;
         endcase
      end
   end

   // decision follows current flags and field.
   // The port copy is registered, so branch_taken lags the field by one edge.
   always_comb begin
      next_taken = core_taken;
   end

   // Bus and core outputs. hreadyout stays low in reset so no master can start a
   // transfer before the register state is valid; from the first edge after release
   // it stays high, since every transfer completes without wait states.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         hrdata       <= 32'h0000_0000;
         hreadyout    <= 1'b0;
         hresp        <= 1'b0;
         flags_out    <= 8'h00;
         branch_taken <= 1'b0;
      end else begin
         hrdata       <= next_hrdata;
         hreadyout    <= 1'b1;
         hresp        <= 1'b0;
         flags_out    <= next_flags;
         branch_taken <= next_taken;
      end
   end

endmodule

// ==== include/cond_eval_pkg.sv ====
// Package with register map, flag layout, condition codes and flag-update actions.
package cond_eval_pkg;

   // Register map: the flag register sits at byte address 0xfc.
   localparam logic [7:0]  ADDR_CONDITION_FLAGS = 8'hfc;
   localparam logic [7:0]  ADDR_CORE_CONTROL    = 8'hf8;
   localparam logic [7:0]  ADDR_BRANCH_STATUS   = 8'hf4;
   localparam logic [31:0] RESET_FLAGS          = 32'h0000_0000;
   localparam logic [31:0] RESET_CONTROL        = 32'h0000_0000;

   // Flag bit positions inside condition_flags.
   localparam int FLAG_C = 7;
   localparam int FLAG_Z = 6;
   localparam int FLAG_S = 5;
   localparam int FLAG_V = 4;
   localparam int FLAG_D = 3;
   localparam int FLAG_H = 2;
   localparam int FLAG_COUNT = 6;
   localparam logic [7:0] FLAGS_MASK = 8'hfc;

   // Control register fields.
   localparam int CTRL_COND_LSB = 0;
   localparam int CTRL_APPLY    = 8;
   localparam int CTRL_ACT_LSB  = 16;
   localparam int ACT_WIDTH     = 3;

   // Bus encodings.
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

   // Condition field encodings.
   typedef enum logic [3:0] {
      COND_NEVER             = 4'h0,
      COND_SIGNED_BELOW      = 4'h1,
      COND_SIGNED_AT_MOST    = 4'h2,
      COND_UNSIGNED_AT_MOST  = 4'h3,
      COND_ARITH_WRAP_SET    = 4'h4,
      COND_SIGN_NEGATIVE     = 4'h5,
      COND_OPERANDS_SAME     = 4'h6,
      COND_UNSIGNED_BELOW    = 4'h7,
      COND_ALWAYS            = 4'h8,
      COND_SIGNED_AT_LEAST   = 4'h9,
      COND_SIGNED_ABOVE      = 4'ha,
      COND_UNSIGNED_ABOVE    = 4'hb,
      COND_ARITH_WRAP_CLEAR  = 4'hc,
      COND_SIGN_POSITIVE     = 4'hd,
      COND_OPERANDS_DIFFER   = 4'he,
      COND_UNSIGNED_AT_LEAST = 4'hf
   } cond_code_t;

   // Per-flag update action of an instruction.
   typedef enum logic [2:0] {
      ACT_KEEP   = 3'h0,
      ACT_CLEAR  = 3'h1,
      ACT_SET    = 3'h2,
      ACT_RESULT = 3'h3,
      ACT_UNDEF  = 3'h4
   } flag_act_t;

   // The four flags the evaluator reads.
   typedef struct packed {
      logic carry;
      logic zero;
      logic sign;
      logic wrap;
   } cond_flags_t;

   // One instruction's flag update request: an action and a result value per flag.
   typedef struct packed {
      logic                       valid;
      flag_act_t [FLAG_COUNT-1:0] act;
      logic [FLAG_COUNT-1:0]      result;
   } flag_update_t;

endpackage

// ==== core/cond_decide.sv ====
// Combinational condition-code decision from four flags and a 4-bit field.
`timescale 1ns/1ps
module cond_decide
   import cond_eval_pkg::*;
(
   input  wire cond_flags_t flags,
   input  wire logic [3:0]  cond,
   output logic             taken
);

   always_comb begin
      unique case (cond_code_t'(cond))
         COND_ALWAYS:            taken = 1'b1;
         COND_NEVER:             taken = 1'b0;
         COND_UNSIGNED_BELOW:    taken = flags.carry;
         COND_UNSIGNED_AT_LEAST: taken = ~flags.carry;
         COND_UNSIGNED_AT_MOST:  taken = flags.carry | flags.zero;
         COND_UNSIGNED_ABOVE:    taken = ~flags.carry & ~flags.zero;
         COND_SIGNED_ABOVE:      taken = ~(flags.zero | (flags.sign ^ flags.wrap));
         COND_SIGNED_AT_MOST:    taken = flags.zero | (flags.sign ^ flags.wrap);
         COND_SIGNED_AT_LEAST:   taken = ~(flags.sign ^ flags.wrap);
         COND_SIGNED_BELOW:      taken = flags.sign ^ flags.wrap;
         COND_OPERANDS_SAME:     taken = flags.zero;
         COND_OPERANDS_DIFFER:   taken = ~flags.zero;
         COND_SIGN_NEGATIVE:     taken = flags.sign;
         COND_SIGN_POSITIVE:     taken = ~flags.sign;
         COND_ARITH_WRAP_SET:    taken = flags.wrap;
         COND_ARITH_WRAP_CLEAR:  taken = ~flags.wrap;
      endcase
   end

endmodule

// ==== tb/branch_condition_evaluator_props.sv ====
// Checker for branch decisions, core flag updates and bus writes of the flag register.
`timescale 1ns/1ps
module branch_condition_evaluator_props
   import cond_eval_pkg::*;
(
   input wire logic         clk_sys,
   input wire logic         reset,
   input wire logic         hsel,
   input wire logic [7:0]   haddr,
   input wire logic [1:0]   htrans,
   input wire logic         hwrite,
   input wire logic [2:0]   hsize,
   input wire logic [31:0]  hwdata,
   input wire logic         hready,
   input wire logic         hreadyout,
   input wire logic         hresp,
   input wire logic [3:0]   cond_field,
   input wire flag_update_t flag_update,
   input wire logic [7:0]   flags_out,
   input wire logic         branch_taken
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic         ok;
   logic         wp;
   logic         p_w;
   logic [7:0]   p_d;
   logic [7:0]   p_f;
   logic [3:0]   p_c;
   flag_update_t p_u;
   logic         x;
   logic         wr_fc;
   // Address phase of a word write to the flag register.
   assign wr_fc = hsel && hready && htrans[1] && hwrite && hsize == HSIZE_WORD && haddr == ADDR_CONDITION_FLAGS;
   assign x = p_f[FLAG_S] ^ p_f[FLAG_V];
   // Inputs kept one edge, because the decision and the flags are registered at the ports.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ok <= 1'b0;
         wp <= 1'b0;
         p_w <= 1'b0;
         p_d <= 8'h00;
         p_f <= 8'h00;
         p_c <= 4'h0;
         p_u <= '0;
      end else begin
         ok <= 1'b1;
         wp <= wr_fc;
         p_w <= wp;
         p_d <= hwdata[7:0];
         p_f <= flags_out;
         p_c <= cond_field;
         p_u <= flag_update;
      end
   end
   // Decision of each condition field from the flags of the edge before.
   a_always_never: assert property (ok && p_c[2:0] == 3'h0 |-> branch_taken == p_c[3])
      else $error("always or never decision wrong");
   a_carry_codes: assert property (ok && p_c[2:0] == 3'h7 |-> branch_taken == (p_f[7] ^ p_c[3]))
      else $error("carry decision wrong");
   a_unsigned_most: assert property (ok && p_c == 4'h3 |-> branch_taken == (p_f[7] | p_f[6]))
      else $error("unsigned at most decision wrong");
   a_unsigned_above: assert property (ok && p_c == 4'hb |-> branch_taken == !(p_f[7] | p_f[6]))
      else $error("unsigned above decision wrong");
   a_signed_above: assert property (ok && p_c == 4'ha |-> branch_taken == !(p_f[6] | x))
      else $error("signed above decision wrong");
   a_signed_most: assert property (ok && p_c == 4'h2 |-> branch_taken == (p_f[6] | x))
      else $error("signed at most decision wrong");
   a_signed_least: assert property (ok && p_c[2:0] == 3'h1 |-> branch_taken == (x ^ p_c[3]))
      else $error("signed at least decision wrong");
   a_single_flag: assert property (ok && p_c[2] && p_c[1:0] != 2'h3 |-> branch_taken == (p_f[p_c[2:0]] ^ p_c[3]))
      else $error("single flag decision wrong");
   // Core update of the carry flag and bus writes of the whole register.
   a_flag_update: assert property (ok && p_u.valid && !p_w |-> flags_out[7] == (p_u.act[5] == ACT_SET ? 1'b1 :
      p_u.act[5] == ACT_CLEAR ? 1'b0 : p_u.act[5] == ACT_KEEP ? p_f[7] : p_u.result[5]))
      else $error("carry flag update wrong");
   a_bus_write: assert property (ok && p_w |-> flags_out == (p_d & FLAGS_MASK))
      else $error("flag register write wrong");
   a_bus_okay: assert property (ok |-> hreadyout && !hresp)
      else $error("bus not ready or not okay");
endmodule
bind branch_condition_evaluator branch_condition_evaluator_props u_branch_condition_evaluator_props (.*);

// ==== tb/branch_condition_evaluator_bench.sv ====
// Bench for the branch condition evaluator: bus access, decisions and flag updates.
`timescale 1ns/1ps
module branch_condition_evaluator_bench import cond_eval_pkg::*;;
   logic         clk_sys;
   logic         reset;
   logic         hsel;
   logic [7:0]   haddr;
   logic [1:0]   htrans;
   logic         hwrite;
   logic [2:0]   hsize;
   logic [31:0]  hwdata;
   wire logic    hready;
   logic [31:0]  hrdata;
   logic         hreadyout;
   logic         hresp;
   logic [3:0]   cond_field;
   flag_update_t flag_update;
   logic [7:0]   flags_out;
   logic         branch_taken;
   int           failures;
   int           compares;
   logic [31:0]  rd;
   logic [7:0]   upd [5] = '{8'ha8, 8'h00, 8'hfc, 8'h64, 8'h64};
   // The single slave drives the bus ready.
   assign hready = hreadyout;
   branch_condition_evaluator u_branch_condition_evaluator (.*);
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One AHB-Lite single transfer; never assumes a wait count.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      hsize <= HSIZE_WORD;
      do @(posedge clk_sys); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hready !== 1'b1);
      r = hrdata;
   endtask
   // Expected decision; f holds carry, zero, sign and wrap from the top down.
   function automatic logic want(input logic [3:0] f, input logic [3:0] c);
      case (c[2:0])
         3'h0: want = c[3];
         3'h7: want = f[3] ^ c[3];
         3'h3: want = (f[3] | f[2]) ^ c[3];
         3'h2: want = (f[2] | (f[1] ^ f[0])) ^ c[3];
         3'h1: want = f[1] ^ f[0] ^ c[3];
         default: want = f[c[1:0]] ^ c[3];
      endcase
   endfunction
   task automatic print_verdict;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Watchdog well beyond the roughly 600 cycles the tests need.
   initial begin
      repeat (3000) @(posedge clk_sys);
      failures++;
      print_verdict;
   end
   initial begin
      reset = 1'b1;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = HSIZE_WORD;
      hwdata = 32'h0;
      cond_field = 4'h0;
      flag_update = '0;
      failures = 0;
      compares = 0;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      xfer(1'b0, ADDR_CONDITION_FLAGS, 32'h0, rd);
      check("flags after reset", 32'h0, rd);
      xfer(1'b0, 8'h00, 32'h0, rd);
      check("unmapped read", 32'h0, rd);
      xfer(1'b1, ADDR_CONDITION_FLAGS, 32'hffff_ffff, rd);
      xfer(1'b0, ADDR_CONDITION_FLAGS, 32'h0, rd);
      check("flags readback", 32'h0000_00fc, rd);
      // Every combination of carry, zero, sign and wrap against every condition field.
      for (int f = 0; f < 16; f++) begin
         xfer(1'b1, ADDR_CONDITION_FLAGS, {24'h0, f[3:0], 4'h0}, rd);
         for (int c = 0; c < 16; c++) begin
            cond_field <= c[3:0];
            repeat (2) @(posedge clk_sys);
            check("branch_taken", {31'h0, want(f[3:0], c[3:0])}, {31'h0, branch_taken});
         end
         check("flags_out", {24'h0, f[3:0], 4'h0}, {24'h0, flags_out});
      end
      // Each update action applied to all six flags from a known preset.
      for (int a = 0; a < 5; a++) begin
         xfer(1'b1, ADDR_CONDITION_FLAGS, 32'h0000_00a8, rd);
         flag_update <= {1'b1, {6{a[2:0]}}, 6'h19};
         @(posedge clk_sys);
         flag_update <= '0;
         @(posedge clk_sys);
         check("flag update", {24'h0, upd[a]}, {24'h0, flags_out});
      end
      // A bus write in the same cycle as a core update wins.
      flag_update <= {1'b1, {6{3'h2}}, 6'h00};
      xfer(1'b1, ADDR_CONDITION_FLAGS, 32'h0000_0024, rd);
      flag_update <= '0;
      xfer(1'b0, ADDR_CONDITION_FLAGS, 32'h0, rd);
      check("bus write wins", 32'h0000_0024, rd);
      // Control storage, branch status word and the apply strobe.
      xfer(1'b1, ADDR_CONDITION_FLAGS, 32'h0000_0080, rd);
      cond_field <= 4'h7;
      xfer(1'b1, ADDR_CORE_CONTROL, 32'h00a5_5a07, rd);
      xfer(1'b0, ADDR_CORE_CONTROL, 32'h0, rd);
      check("control readback", 32'h00a5_5a07, rd);
      xfer(1'b0, ADDR_BRANCH_STATUS, 32'h0, rd);
      check("branch status", 32'h0000_0003, rd);
      cond_field <= 4'h8;
      xfer(1'b0, ADDR_BRANCH_STATUS, 32'h0, rd);
      check("branch status other code", 32'h0000_0001, rd);
      xfer(1'b1, ADDR_CORE_CONTROL, 32'h0001_0100, rd);
      xfer(1'b0, ADDR_CONDITION_FLAGS, 32'h0, rd);
      check("apply clear", 32'h0, rd);
      xfer(1'b0, ADDR_CORE_CONTROL, 32'h0, rd);
      check("apply reads back 0", 32'h0001_0000, rd);
      xfer(1'b1, ADDR_CORE_CONTROL, 32'h0002_0100, rd);
      xfer(1'b0, ADDR_CONDITION_FLAGS, 32'h0, rd);
      check("apply set", 32'h0000_00fc, rd);
      xfer(1'b1, ADDR_CORE_CONTROL, 32'h0000_0008, rd);
      cond_field <= 4'h0;
      xfer(1'b0, ADDR_BRANCH_STATUS, 32'h0, rd);
      check("status stored always", 32'h0000_0002, rd);
      print_verdict;
   end
endmodule
